// ---- rtctc_pkg.sv ----
// shared constants for the time counter and event flag block
package rtctc_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] IDX_CTRL   = 16'h56c0;  // clock_control_register
  localparam logic [15:0] IDX_IEN    = 16'h56c2;  // interrupt enable register
  localparam logic [15:0] IDX_FLAGS  = 16'h56c4;  // clock_event_flags
  localparam logic [15:0] IDX_MINSEC = 16'h56c6;  // minute_second_count
  localparam logic [15:0] IDX_HOUR   = 16'h56c8;  // hour_count

  localparam logic [31:0] ADDR_CTRL   = {14'h0000, IDX_CTRL, 2'h0};
  localparam logic [31:0] ADDR_IEN    = {14'h0000, IDX_IEN, 2'h0};
  localparam logic [31:0] ADDR_FLAGS  = {14'h0000, IDX_FLAGS, 2'h0};
  localparam logic [31:0] ADDR_MINSEC = {14'h0000, IDX_MINSEC, 2'h0};
  localparam logic [31:0] ADDR_HOUR   = {14'h0000, IDX_HOUR, 2'h0};

  // control register fields
  localparam int CTRL_RUN_BIT    = 0;  // count_run_control
  localparam int CTRL_FMT_BIT    = 4;  // hour_format_select, 1 = 12-hour
  localparam int CTRL_BCD_BIT    = 5;  // decimal_encoding_select
  localparam int CTRL_STATUS_BIT = 8;  // count_running_status

  // flag and enable bit positions
  localparam int FLAG_32HZ  = 0;
  localparam int FLAG_8HZ   = 1;
  localparam int FLAG_4HZ   = 2;
  localparam int FLAG_1HZ   = 3;
  localparam int FLAG_10SEC = 4;
  localparam int FLAG_1MIN  = 5;
  localparam int FLAG_10MIN = 6;
  localparam int FLAG_1HOUR = 7;
  localparam int FLAG_HALF  = 8;
  localparam int FLAG_DAY   = 9;
  localparam int NUM_FLAGS  = 10;

  // counter register fields
  localparam int SEC_LSB  = 0;
  localparam int MIN_LSB  = 8;
  localparam int HOUR_LSB = 0;
  localparam int PM_BIT   = 7;

  // divider tap positions on the tick input
  localparam int TAP_32HZ = 0;
  localparam int TAP_1HZ  = 3;
  localparam int NUM_TAPS = 4;

  // counting limits, binary and bcd
  localparam logic [6:0] MS_MAX_BIN  = 7'h3b;
  localparam logic [6:0] MS_MAX_BCD  = 7'h59;
  localparam logic [5:0] H24_MAX_BIN = 6'h17;
  localparam logic [5:0] H24_MAX_BCD = 6'h23;
  localparam logic [5:0] H12_ELEVEN_BIN = 6'h0b;
  localparam logic [5:0] H12_ELEVEN_BCD = 6'h11;
  localparam logic [5:0] H12_TWELVE_BIN = 6'h0c;
  localparam logic [5:0] H12_TWELVE_BCD = 6'h12;
  localparam logic [5:0] H12_ONE        = 6'h01;

  // values after reset
  localparam logic [9:0]  FLAGS_RESET = 10'h000;
  localparam logic [9:0]  IEN_RESET   = 10'h000;
  localparam logic [6:0]  COUNT_RESET = 7'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage : rtctc_pkg

// ---- rtctc_top.sv ----
`timescale 1ns/1ns
module rtctc_top
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // divider taps from the slow oscillator: 32, 8, 4, 1 hz
  // asynchronous to CLOCK, so they are synchronised inside
  input  wire logic [3:0]  DIVIDER_TAPS,
  // request to the interrupt_controller
  output logic             INT_REQ
);

  // complete block state, registered as one word
  // adding a field needs no change to the register process
  typedef struct packed {
    logic        run;        // count_run_control
    logic        fmt12;      // hour_format_select
    logic        bcd;        // decimal_encoding_select
    logic        running;    // count_running_status
    logic [9:0]  ien;        // per-period enables
    logic [9:0]  flg;        // clock_event_flags
    logic [6:0]  sec;        // second_value
    logic [6:0]  min;        // minute_value
    logic [5:0]  hour;       // hour_value
    logic        pm;         // afternoon_indicator
    logic [3:0]  tap_s1;     // synchroniser first stage
    logic [3:0]  tap_s2;     // synchroniser second stage
    logic [3:0]  tap_s3;     // edge detect history
    logic [31:0] prdata;     // read data to the bus
    logic        pready;     // access completion
    logic        pslverr;    // unmapped address answer
    logic        irq;        // interrupt request
  } rtctc_state_t;

  rtctc_state_t st_q;  // current state
  rtctc_state_t st_d;  // next state

  // the counters step in whichever encoding is selected now;
  // flipping the encoding bit does not convert the stored value,
  // so software reloads the counters after changing it

  // the tens flag also fires on the wrap, as 59 to 0 is a tens rollover
  // minute/second step: returns {wrap, tens rollover, next value}
  function automatic logic [8:0] step_ms(input logic [6:0] cur, input logic bcd);
    logic [6:0] nxt;
    logic       wrap;
    logic       tens;
    nxt  = 7'h00;
    wrap = 1'b0;
    tens = 1'b0;
    // defaults cover the wrap: next value zero
    // bcd: units roll at 9 and carry into the three-bit tens digit
    if (bcd)
    begin
      if (cur == rtctc_pkg::MS_MAX_BCD)  // 59 back to 00
      begin
        wrap = 1'b1;
        tens = 1'b1;
      end
      else if (cur[3:0] == 4'h9)  // units roll into tens
      begin
        nxt  = {cur[6:4] + 3'h1, 4'h0};
        tens = 1'b1;
      end
      else
      begin
        nxt = cur + 7'h01;
      end
    end
    else
    begin
      // binary: rollover points are compared against the next value
      if (cur == rtctc_pkg::MS_MAX_BIN)  // 59 back to 0
      begin
        wrap = 1'b1;
        tens = 1'b1;
      end
      else
      begin
        nxt = cur + 7'h01;
        // binary tens rollover points
        tens = (nxt == 7'h0a) || (nxt == 7'h14) || (nxt == 7'h1e) ||
               (nxt == 7'h28) || (nxt == 7'h32);
      end
    end
    return {wrap, tens, nxt};
  endfunction : step_ms

  // day is only set on the wrap into the new morning
  // hour step: returns {day, half day, next pm, next hour}
  function automatic logic [8:0] step_hour(input logic [5:0] cur, input logic pm,
                                           input logic bcd, input logic fmt12);
    logic [5:0] nxt;
    logic [5:0] eleven;
    logic [5:0] twelve;
    logic       npm;
    logic       day;
    logic       half;
    eleven = bcd ? rtctc_pkg::H12_ELEVEN_BCD : rtctc_pkg::H12_ELEVEN_BIN;
    twelve = bcd ? rtctc_pkg::H12_TWELVE_BCD : rtctc_pkg::H12_TWELVE_BIN;
    npm    = pm;
    day    = 1'b0;
    half   = 1'b0;
    // out-of-range loads count on naturally; software keeps them legal
    // plain increment in the selected encoding
    if (bcd && (cur[3:0] == 4'h9))
      nxt = {cur[5:4] + 2'h1, 4'h0};
    else
      nxt = cur + 6'h01;
    // 12-hour: no zero hour; eleven is where morning and afternoon meet
    if (fmt12)
    begin
      if (cur == twelve)  // 12 goes to 1
      begin
        nxt = rtctc_pkg::H12_ONE;
      end
      else if (cur == eleven)  // 11 to 12 flips morning/afternoon
      begin
        npm  = ~pm;
        half = 1'b1;
        day  = pm;  // 11pm to 12am
      end
    end
    else
    begin
      // 24-hour: afternoon bit has no meaning and stays clear
      npm = 1'b0;
      if (cur == (bcd ? rtctc_pkg::H24_MAX_BCD : rtctc_pkg::H24_MAX_BIN))  // 23 to 0
      begin
        nxt  = 6'h00;
        day  = 1'b1;
        half = 1'b1;
      end
      // noon is the other half-day point
      else if (nxt == twelve)  // 11 to 12
      begin
        half = 1'b1;
      end
    end
    return {day, half, npm, nxt};
  endfunction : step_hour

  // next-state logic
  always_comb
  begin
    logic [3:0]  tick;      // one-cycle divider edges while running
    logic [9:0]  events;    // flag causes this cycle
    logic [9:0]  clr;       // write-one-to-clear mask
    logic [8:0]  sec_step;  // seconds step result
    logic [8:0]  min_step;  // minutes step result
    logic [8:0]  hr_step;   // hours step result
    logic        access;    // apb access phase
    logic        wr_done;   // write completes this edge
    logic        hit;       // address is mapped
    logic [31:0] rdata;     // read mux
    st_d     = st_q;
    events   = 10'h000;
    clr      = 10'h000;
    access   = PSEL && PENABLE;
    wr_done  = access && st_q.pready && PWRITE;
    hit      = 1'b1;
    rdata    = 32'h00000000;
    // locals get a value first so no path leaves them unset
    tick     = 4'h0;
    sec_step = 9'h000;
    min_step = 9'h000;
    hr_step  = 9'h000;

    // divider taps cross in through two flops, third flop for edges
    // the first flop may go metastable; only the second is read onward
    st_d.tap_s1 = DIVIDER_TAPS;
    st_d.tap_s2 = st_q.tap_s1;
    st_d.tap_s3 = st_q.tap_s2;
    tick = st_q.tap_s2 & ~st_q.tap_s3 & {rtctc_pkg::NUM_TAPS{st_q.running}};
    // a tap edge seen while stopped is dropped, not held for later

    // status lags run control by one cycle both ways
    // stop takes effect on the same lag, so status falls only once halted
    st_d.running = st_q.run;

    // divider period flags
    events[rtctc_pkg::FLAG_32HZ +: rtctc_pkg::NUM_TAPS] = tick;

    // time of day chain, advanced on the 1 hz edge
    sec_step = step_ms(st_q.sec, st_q.bcd);
    min_step = step_ms(st_q.min, st_q.bcd);
    hr_step  = step_hour(st_q.hour, st_q.pm, st_q.bcd, st_q.fmt12);
    // all three steps are worked out every cycle; the carries pick which land
    if (tick[rtctc_pkg::TAP_1HZ])
    begin
      st_d.sec = sec_step[6:0];
      events[rtctc_pkg::FLAG_10SEC] = sec_step[7];
      events[rtctc_pkg::FLAG_1MIN]  = sec_step[8];
      if (sec_step[8])  // carry into minutes
      begin
        st_d.min = min_step[6:0];
        events[rtctc_pkg::FLAG_10MIN] = min_step[7];
        events[rtctc_pkg::FLAG_1HOUR] = min_step[8];
        if (min_step[8])  // carry into hours
        begin
          st_d.hour = hr_step[5:0];
          st_d.pm   = hr_step[6];
          events[rtctc_pkg::FLAG_HALF] = hr_step[7];
          events[rtctc_pkg::FLAG_DAY]  = hr_step[8];
        end
      end
    end
    // loaded values can raise a flag on the very first tick after start
    // disabled causes never set their flag at all
    events = events & st_q.ien;

    // read mux, reserved bits stay zero
    // register map, one word each:
    //   control: run, format, encoding, running status
    //   enables: one bit per period; flags: write one to clear
    //   minute/second: seconds low, minutes from bit 8
    //   hour: hour low, afternoon bit above a reserved bit
    unique case (PADDR)
      rtctc_pkg::ADDR_CTRL:
      begin
        rdata[rtctc_pkg::CTRL_RUN_BIT]    = st_q.run;
        rdata[rtctc_pkg::CTRL_FMT_BIT]    = st_q.fmt12;
        rdata[rtctc_pkg::CTRL_BCD_BIT]    = st_q.bcd;
        rdata[rtctc_pkg::CTRL_STATUS_BIT] = st_q.running;
      end
      rtctc_pkg::ADDR_IEN:
        rdata[9:0] = st_q.ien;
      rtctc_pkg::ADDR_FLAGS:
        rdata[9:0] = st_q.flg;
      rtctc_pkg::ADDR_MINSEC:
      begin
        rdata[rtctc_pkg::SEC_LSB +: 7] = st_q.sec;
        rdata[rtctc_pkg::MIN_LSB +: 7] = st_q.min;
      end
      rtctc_pkg::ADDR_HOUR:
      begin
        rdata[rtctc_pkg::HOUR_LSB +: 6] = st_q.hour;
        rdata[rtctc_pkg::PM_BIT]        = st_q.pm;
      end
      default:
        hit = 1'b0;  // unmapped: error answer, zero data
    endcase

    // one wait state: ready is registered high for the second access cycle
    // data and error are captured one cycle early so they leave a flop
    // pready falls in the cycle after it rose, so an access takes two cycles
    if (access && !st_q.pready)
    begin
      st_d.pready  = 1'b1;
      st_d.prdata  = rdata;
      st_d.pslverr = !hit;
    end
    else
    begin
      st_d.pready  = 1'b0;
      st_d.prdata  = rtctc_pkg::RDATA_RESET;
      st_d.pslverr = 1'b0;
    end

    // register writes take effect at the completing edge
    // a write in the same edge as a tick wins over the count
    if (wr_done && hit)
    begin
      // the same decode as the read side, so the two cannot disagree
      unique case (PADDR)
        // status bit is read only, never written
        rtctc_pkg::ADDR_CTRL:
        begin
          st_d.run   = PWDATA[rtctc_pkg::CTRL_RUN_BIT];
          st_d.fmt12 = PWDATA[rtctc_pkg::CTRL_FMT_BIT];
          st_d.bcd   = PWDATA[rtctc_pkg::CTRL_BCD_BIT];
        end
        // enables gate new events and the request; they never clear a flag
        rtctc_pkg::ADDR_IEN:
          st_d.ien = PWDATA[9:0];
        // ones clear, zeros leave a flag alone
        rtctc_pkg::ADDR_FLAGS:
          clr = PWDATA[9:0];
        rtctc_pkg::ADDR_MINSEC:
        begin
          // a load while counting may collide with a step; software avoids it
          st_d.sec = PWDATA[rtctc_pkg::SEC_LSB +: 7];
          st_d.min = PWDATA[rtctc_pkg::MIN_LSB +: 7];
        end
        // afternoon bit may still be dropped below
        rtctc_pkg::ADDR_HOUR:
        begin
          st_d.hour = PWDATA[rtctc_pkg::HOUR_LSB +: 6];
          st_d.pm   = PWDATA[rtctc_pkg::PM_BIT];
        end
        default:
          clr = 10'h000;
      endcase
    end

    // afternoon bit held at zero whenever 24-hour format is selected
    // this also swallows a pm write while in 24-hour format
    if (!st_d.fmt12)
      st_d.pm = 1'b0;

    // new events win over a same-cycle clear
    // a clear that races a new event loses, so no event is missed
    st_d.flg = (st_q.flg & ~clr) | events;

    // request only for enabled, pending causes
    // level request: stays high until the flag or its enable is cleared
    st_d.irq = |(st_d.flg & st_d.ien);
  end

  // state register; counters also start from zero for determinism
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // counters have no defined start value; zero keeps runs repeatable
      st_q         <= '0;
      st_q.flg     <= rtctc_pkg::FLAGS_RESET;
      st_q.ien     <= rtctc_pkg::IEN_RESET;
      st_q.sec     <= rtctc_pkg::COUNT_RESET;
      st_q.min     <= rtctc_pkg::COUNT_RESET;
      st_q.prdata  <= rtctc_pkg::RDATA_RESET;
    end
    else
    begin
      // every field updates on every edge; no enables
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign PRDATA  = st_q.prdata;
  assign PREADY  = st_q.pready;
  assign PSLVERR = st_q.pslverr;
  assign INT_REQ = st_q.irq;

endmodule : rtctc_top

// ---- rtctc_checker.sv ----
`timescale 1ns/1ns
module rtctc_checker
(
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RSTN,
  // apb slave side
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // divider taps and request
  input wire logic [3:0]  DIVIDER_TAPS,
  input wire logic        INT_REQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  logic       wr_done;  // completed write
  logic       rd_done;  // completed read
  logic [2:0] mode_q;   // bcd, 12-hour, run as last written

  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;

  // mirror the mode bits from the bus, since the body is hidden
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode_q <= 3'h0;
    end
    else if (wr_done && PADDR == rtctc_pkg::ADDR_CTRL)
    begin
      mode_q <= {PWDATA[rtctc_pkg::CTRL_BCD_BIT], PWDATA[rtctc_pkg::CTRL_FMT_BIT],
                 PWDATA[rtctc_pkg::CTRL_RUN_BIT]};
    end
  end

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_first;
    s_setup ##1 (PSEL && PENABLE);
  endsequence

  property p_ready_wait;
    s_first |=> PREADY;
  endproperty
  property p_ien_off;
    wr_done && PADDR == rtctc_pkg::ADDR_IEN && PWDATA[9:0] == 10'h000 |-> ##2 !INT_REQ [*4];
  endproperty
  property p_status;
    rd_done && PADDR == rtctc_pkg::ADDR_CTRL |-> PRDATA[8] == mode_q[0] && PRDATA[31:9] == 23'h0;
  endproperty
  property p_flag_resv;
    rd_done && PADDR == rtctc_pkg::ADDR_FLAGS |-> PRDATA[31:10] == 22'h0;
  endproperty
  property p_ms_resv;
    rd_done && PADDR == rtctc_pkg::ADDR_MINSEC |-> PRDATA[31:15] == 17'h0 && !PRDATA[7];
  endproperty
  property p_pm_24;
    rd_done && PADDR == rtctc_pkg::ADDR_HOUR && !mode_q[1] |-> PRDATA[31:6] == 26'h0;
  endproperty
  property p_bcd_ms;
    rd_done && PADDR == rtctc_pkg::ADDR_MINSEC && mode_q[2] |->
      PRDATA[14:12] <= 3'h5 && PRDATA[11:8] <= 4'h9 && PRDATA[6:4] <= 3'h5 && PRDATA[3:0] <= 4'h9;
  endproperty
  property p_bin_ms;
    rd_done && PADDR == rtctc_pkg::ADDR_MINSEC && !mode_q[2] |-> PRDATA[14:8] <= 7'h3b && PRDATA[6:0] <= 7'h3b;
  endproperty
  property p_err_ready;
    PSLVERR |-> PREADY && PRDATA == 32'h00000000;
  endproperty
  property p_bin_hour;
    rd_done && PADDR == rtctc_pkg::ADDR_HOUR && mode_q[2:1] == 2'h0 |-> PRDATA[5:0] <= 6'h17;
  endproperty

  a_ready_wait: assert property (p_ready_wait) else $error("pready not one cycle after access");
  a_ien_off: assert property (p_ien_off) else $error("request with all enables off");
  a_status: assert property (p_status) else $error("running status wrong");
  a_flag_resv: assert property (p_flag_resv) else $error("flag reserved bits set");
  a_ms_resv: assert property (p_ms_resv) else $error("min/sec reserved bits set");
  a_pm_24: assert property (p_pm_24) else $error("afternoon bit set in 24-hour");
  a_bcd_ms: assert property (p_bcd_ms) else $error("bcd min/sec digit out of range");
  a_bin_ms: assert property (p_bin_ms) else $error("binary min/sec out of range");
  a_bin_hour: assert property (p_bin_hour) else $error("binary hour out of range");
  a_err_ready: assert property (p_err_ready) else $error("error answer without ready or with data");
endmodule : rtctc_checker

bind rtctc_top rtctc_checker u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .DIVIDER_TAPS(DIVIDER_TAPS), .INT_REQ(INT_REQ));

// ---- rtctc_top_tb.sv ----
`timescale 1ns/1ns
module rtctc_top_tb;
  // design ports
  logic        CLOCK;
  logic        RSTN;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [31:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [3:0]  DIVIDER_TAPS;
  logic        INT_REQ;
  // bench state
  logic [31:0] rd_q;
  logic        err_q;
  int          err_count;
  int          checked;

  rtctc_top uut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DIVIDER_TAPS(DIVIDER_TAPS), .INT_REQ(INT_REQ));

  // 250 mhz clock
  always #2 CLOCK = ~CLOCK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_count++;
      print_verdict;
    end
    rd_q = PRDATA;
    err_q = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // idle edge so the next setup never lands on this release
    @(posedge CLOCK);
  endtask : apb

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd_q, exp);
  endtask : rchk

  // one divider period; long enough for the synchroniser
  task automatic tick(input int i);
    DIVIDER_TAPS <= DIVIDER_TAPS | (4'h1 << i);
    repeat (8) @(posedge CLOCK);
    DIVIDER_TAPS <= DIVIDER_TAPS & ~(4'h1 << i);
    repeat (8) @(posedge CLOCK);
  endtask : tick

  task automatic t_regs;
    rchk(rtctc_pkg::ADDR_FLAGS, 32'h00000000);
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'hffffffff);
    rchk(rtctc_pkg::ADDR_IEN, 32'h000003ff);
    apb(1'b0, 32'h00000100, 32'h00000000);
    chk({31'h0, err_q}, 32'h00000001);
    chk(rd_q, 32'h00000000);
  endtask : t_regs

  task automatic t_divider;
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'h0000000f);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, 32'h00000001);
    rchk(rtctc_pkg::ADDR_CTRL, 32'h00000101);
    for (int i = 0; i < 4; i++)
      tick(i);
    rchk(rtctc_pkg::ADDR_FLAGS, 32'h0000000f);
    chk({31'h0, INT_REQ}, 32'h00000001);
    apb(1'b1, rtctc_pkg::ADDR_FLAGS, 32'h00000005);
    rchk(rtctc_pkg::ADDR_FLAGS, 32'h0000000a);
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'h00000001);
    repeat (2) @(posedge CLOCK);
    chk({31'h0, INT_REQ}, 32'h00000000);
    tick(2);
    rchk(rtctc_pkg::ADDR_FLAGS, 32'h0000000a);
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'h00000008);
    chk({31'h0, INT_REQ}, 32'h00000001);
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'h00000000);
    chk({31'h0, INT_REQ}, 32'h00000000);
    apb(1'b1, rtctc_pkg::ADDR_FLAGS, 32'h000003ff);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, 32'h00000000);
  endtask : t_divider

  // load while stopped, run for one second, stop and compare
  task automatic t_wrap(input logic [31:0] mode, hr, ms, eh, ems, ef);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, mode);
    rchk(rtctc_pkg::ADDR_CTRL, mode);
    apb(1'b1, rtctc_pkg::ADDR_HOUR, hr);
    apb(1'b1, rtctc_pkg::ADDR_MINSEC, ms);
    apb(1'b1, rtctc_pkg::ADDR_FLAGS, 32'h000003ff);
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'h000003f0);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, mode | 32'h00000001);
    tick(3);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, mode);
    rchk(rtctc_pkg::ADDR_MINSEC, ems);
    rchk(rtctc_pkg::ADDR_HOUR, eh);
    rchk(rtctc_pkg::ADDR_FLAGS, ef);
  endtask : t_wrap

  task automatic t_pm;
    apb(1'b1, rtctc_pkg::ADDR_CTRL, 32'h00000010);
    apb(1'b1, rtctc_pkg::ADDR_HOUR, 32'h00000085);
    rchk(rtctc_pkg::ADDR_HOUR, 32'h00000085);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, 32'h00000000);
    rchk(rtctc_pkg::ADDR_HOUR, 32'h00000005);
  endtask : t_pm

  // a reset in mid-run clears flags, control and the request
  task automatic t_reset;
    apb(1'b1, rtctc_pkg::ADDR_IEN, 32'h00000008);
    apb(1'b1, rtctc_pkg::ADDR_CTRL, 32'h00000001);
    tick(3);
    chk({31'h0, INT_REQ}, 32'h00000001);
    RSTN <= 1'b0;
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    chk({31'h0, INT_REQ}, 32'h00000000);
    rchk(rtctc_pkg::ADDR_FLAGS, 32'h00000000);
    rchk(rtctc_pkg::ADDR_CTRL, 32'h00000000);
  endtask : t_reset

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    CLOCK = 1'b0;
    RSTN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 32'h00000000;
    PWDATA = 32'h00000000;
    DIVIDER_TAPS = 4'h0;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    t_regs;
    t_divider;
    t_wrap(32'h00, 32'h17, 32'h3b3b, 32'h00, 32'h0000, 32'h3f0);
    t_wrap(32'h00, 32'h05, 32'h093b, 32'h05, 32'h0a00, 32'h070);
    t_wrap(32'h20, 32'h23, 32'h5959, 32'h00, 32'h0000, 32'h3f0);
    t_wrap(32'h10, 32'h8b, 32'h3b3b, 32'h0c, 32'h0000, 32'h3f0);
    t_wrap(32'h30, 32'h11, 32'h5959, 32'h92, 32'h0000, 32'h1f0);
    t_wrap(32'h10, 32'h8c, 32'h3b3b, 32'h81, 32'h0000, 32'h0f0);
    t_wrap(32'h00, 32'h0b, 32'h3b3b, 32'h0c, 32'h0000, 32'h1f0);
    t_wrap(32'h00, 32'h00, 32'h0009, 32'h00, 32'h000a, 32'h010);
    t_wrap(32'h20, 32'h00, 32'h0009, 32'h00, 32'h0010, 32'h010);
    t_pm;
    t_reset;
    print_verdict;
  end

  // watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    #100000;
    err_count++;
    print_verdict;
  end
endmodule : rtctc_top_tb
